// File: hw/vdc_pkg.sv
// Behaviour
// - Status bit 7 shows horizontal sync present.
// - Status bit 6 shows active horizontal sync source.
// - Status bit 5 shows input horizontal sync polarity.
// - Status bit 4 shows vertical sync present.
// - Status bit 3 shows active vertical sync source.
// - Status bit 2 shows output vertical polarity.
// - Status bit 1 shows green-channel sync present.
// - Status bit 0 shows PLL hold input polarity.
// - Output mode bit 7 selects dual channel.
// - Output mode bit 6 selects parallel output.
// - Output mode bit 5 picks first port.
// - Output mode bit 0 bypasses PLL clock.
// - Register zero reads fixed silicon revision.
// - Divider is high byte plus low nibble.
// - High byte waits until low register written.
// - High byte write alone keeps divider.
// - Divider resets to 1693.
// - Register three bits 7-6 select oscillator range.
// - Register three bits 5-3 select pump current.
// - Register four bits 7-3 set sampling phase.
package vdc_pkg;

  // Register offsets on the serial port.
  localparam logic [7:0] VDC_ADDR_REVISION = 8'h00;
  localparam logic [7:0] VDC_ADDR_DIV_HIGH = 8'h01;
  localparam logic [7:0] VDC_ADDR_DIV_LOW = 8'h02;
  localparam logic [7:0] VDC_ADDR_CLK_GEN = 8'h03;
  localparam logic [7:0] VDC_ADDR_PHASE = 8'h04;
  localparam logic [7:0] VDC_ADDR_STATUS = 8'h14;
  localparam logic [7:0] VDC_ADDR_OUT_MODE = 8'h15;
  localparam logic [7:0] VDC_ADDR_TEST_A = 8'h16;
  localparam logic [7:0] VDC_ADDR_TEST_B = 8'h17;
  localparam logic [7:0] VDC_ADDR_TEST_C = 8'h18;
  localparam logic [7:0] VDC_ADDR_TEST_D = 8'h19;

  // Values after reset.
  localparam logic [7:0] VDC_RST_DIV_HIGH = 8'h69;
  localparam logic [3:0] VDC_RST_DIV_LOW = 4'hD;
  localparam logic [1:0] VDC_RST_OSC_RANGE = 2'h1;
  localparam logic [2:0] VDC_RST_PUMP = 3'h1;
  localparam logic [4:0] VDC_RST_PHASE = 5'h10;
  localparam logic [7:0] VDC_RST_OUT_MODE = 8'hC6;
  localparam logic [7:0] VDC_RST_TEST_A = 8'hFF;
  localparam logic [4:0] VDC_RST_TEST_B = 5'h00;

  // Field positions in the output mode register.
  localparam int VDC_OM_DUAL = 7;
  localparam int VDC_OM_PARALLEL = 6;
  localparam int VDC_OM_PORT_B = 5;
  localparam int VDC_OM_FMT422 = 4;
  localparam int VDC_OM_MUX = 3;
  localparam int VDC_OM_BW_HI = 2;
  localparam int VDC_OM_BW_LO = 1;
  localparam int VDC_OM_EXT_CLK = 0;

  // Serial slave states, Gray coded along the write path.
  typedef enum logic [3:0] {
    VDC_IDLE = 4'h0,
    VDC_DEV = 4'h1,
    VDC_DEV_ACK = 4'h3,
    VDC_SUB = 4'h2,
    VDC_SUB_ACK = 4'h6,
    VDC_WR = 4'h7,
    VDC_WR_ACK = 4'h5,
    VDC_RD = 4'h4,
    VDC_RD_ACK = 4'hC
  } vdc_state_t;

endpackage

// File: hw/vdc_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for signals from outside the clock domain.
module vdc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in, // Core clock.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised input.
  output logic [WIDTH-1:0] sync_out // Synchronised output.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } vdc_sync_t;

  vdc_sync_t s_q;
  vdc_sync_t s_d;

  // Refuse a width that leaves nothing to carry.
  if (WIDTH < 1) begin : g_chk
    $error("vdc_sync2 needs WIDTH of at least one");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  // Both stages clear on reset.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule

// File: hw/vdc_div_stage.sv
`timescale 1ns/1ps
// Holds the written high divider byte and the divider in use.
module vdc_div_stage (
  input wire logic ref_clk_in, // Core clock.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic wr_high_in, // Write strobe for the high byte.
  input wire logic wr_low_in, // Write strobe for the low nibble.
  input wire logic [7:0] data_in, // Written byte.
  output logic [7:0] high_out, // Pending high byte, for read back.
  output logic [11:0] divider_out // Divider value in use.
);

  typedef struct packed {
    logic [7:0] pend;
    logic [11:0] active;
  } vdc_div_t;

  vdc_div_t s_q;
  vdc_div_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_high_in) begin
      s_d.pend = data_in;
    end
    if (wr_low_in) begin
      s_d.active = {s_q.pend, data_in[7:4]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q.pend <= vdc_pkg::VDC_RST_DIV_HIGH;
      s_q.active <= {vdc_pkg::VDC_RST_DIV_HIGH, vdc_pkg::VDC_RST_DIV_LOW};
    end else begin
      s_q <= s_d;
    end
  end

  assign high_out = s_q.pend;
  assign divider_out = s_q.active;

endmodule

// File: hw/vdc_ctrl_regs.sv
`timescale 1ns/1ps
// Control and status register bank of the video digitizer, reached over
// the 2-wire serial control port. The slave samples SDA on SCL rising
// edges and changes its own SDA drive only on SCL falling edges.
module vdc_ctrl_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h4C, // Serial device address.
  parameter logic [7:0] SILICON_REV = 8'h5A // Arbitrary revision value.
) (
  input wire logic ref_clk_in, // Core clock, 40 MHz.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic scl_in, // Serial clock pin.
  input wire logic sda_in, // Serial data pin level.
  output logic sda_out, // Serial data drive level.
  output logic sda_oe_out, // Serial data drive enable, high drives.
  input wire logic hsync_detect_in, // Horizontal sync present.
  input wire logic active_hsync_source_in, // Horizontal sync from green.
  input wire logic hsync_polarity_in, // Input horizontal sync high.
  input wire logic vsync_detect_in, // Vertical sync present.
  input wire logic active_vsync_source_in, // Vertical sync from separator.
  input wire logic vsync_out_polarity_in, // Output vertical sync low.
  input wire logic green_sync_detect_in, // Sync found on green.
  input wire logic pll_hold_polarity_in, // PLL hold input high.
  input wire logic [7:0] test_c_in, // Third test register value.
  input wire logic [7:0] test_d_in, // Fourth test register value.
  output logic [11:0] pixel_clock_divider_out, // Divider in use.
  output logic [1:0] oscillator_range_out, // Oscillator range code.
  output logic [2:0] pump_current_out, // Charge pump current code.
  output logic [4:0] sampling_phase_out, // Sampling phase step.
  output logic dual_channel_out, // Dual-channel output mode.
  output logic parallel_out, // Parallel output mode.
  output logic port_b_first_out, // First byte on port B.
  output logic format_422_out, // 4:2:2 output formatting.
  output logic input_mux_out, // Input mux control.
  output logic [1:0] input_bw_out, // Input bandwidth code.
  output logic pll_bypass_out, // External clock replaces PLL.
  output logic [7:0] test_a_out, // First test register.
  output logic [4:0] test_b_out // Second test register, bits 7-3.
);

  typedef struct packed {
    vdc_pkg::vdc_state_t st;
    logic [2:0] cnt;
    logic acked;
    logic rd_mode;
    logic [7:0] shift;
    logic [7:0] tx;
    logic oe;
    logic [7:0] ptr;
    logic scl_prev;
    logic sda_prev;
    logic [4:0] clk_gen;
    logic [4:0] phase;
    logic [7:0] out_mode;
    logic [7:0] test_a;
    logic [4:0] test_b;
  } vdc_state_s_t;

  vdc_state_s_t s_q;
  vdc_state_s_t s_d;

  logic scl_s;
  logic sda_s;
  logic [1:0] pins_inv_s;
  logic [23:0] stat_s;
  logic [7:0] status_byte;
  logic [7:0] div_high;
  logic [11:0] div_active;
  logic wr_high;
  logic wr_low;
  logic [7:0] wr_byte;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rx_byte;

  // Bus pins pass two flip-flops inverted, so the cleared stages match the idle
  // high bus and no false clock edge is seen right after reset.
  vdc_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .async_in(~{scl_in, sda_in}),
    .sync_out(pins_inv_s)
  );

  // True pin levels again.
  assign scl_s = ~pins_inv_s[1];
  assign sda_s = ~pins_inv_s[0];

  // Status and test inputs come from the sync processing domain.
  vdc_sync2 #(
    .WIDTH(24)
  ) u_stat_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .async_in({hsync_detect_in, active_hsync_source_in, hsync_polarity_in,
               vsync_detect_in, active_vsync_source_in, vsync_out_polarity_in,
               green_sync_detect_in, pll_hold_polarity_in, test_c_in, test_d_in}),
    .sync_out(stat_s)
  );

  // The pending high byte and the applied divider live here.
  vdc_div_stage u_div (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_high_in(wr_high),
    .wr_low_in(wr_low),
    .data_in(wr_byte),
    .high_out(div_high),
    .divider_out(div_active)
  );

  assign status_byte = stat_s[23:16];

  // Bus events seen on the synchronised pins.
  assign rise = scl_s & ~s_q.scl_prev;
  assign fall = ~scl_s & s_q.scl_prev;
  assign start_cond = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
  assign stop_cond = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
  assign rx_byte = {s_q.shift[6:0], sda_s};

  // Read multiplexer; unmapped offsets read as zero.
  function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                        input vdc_state_s_t q,
                                        input logic [7:0] stat,
                                        input logic [7:0] dh,
                                        input logic [11:0] dv,
                                        input logic [15:0] tcd);
    logic [7:0] v;
    v = 8'h00;
    if (addr == vdc_pkg::VDC_ADDR_REVISION) begin
      v = SILICON_REV;
    end else if (addr == vdc_pkg::VDC_ADDR_DIV_HIGH) begin
      v = dh;
    end else if (addr == vdc_pkg::VDC_ADDR_DIV_LOW) begin
      v = {dv[3:0], 4'h0};
    end else if (addr == vdc_pkg::VDC_ADDR_CLK_GEN) begin
      v = {q.clk_gen, 3'h0};
    end else if (addr == vdc_pkg::VDC_ADDR_PHASE) begin
      v = {q.phase, 3'h0};
    end else if (addr == vdc_pkg::VDC_ADDR_STATUS) begin
      v = stat;
    end else if (addr == vdc_pkg::VDC_ADDR_OUT_MODE) begin
      v = q.out_mode;
    end else if (addr == vdc_pkg::VDC_ADDR_TEST_A) begin
      v = q.test_a;
    end else if (addr == vdc_pkg::VDC_ADDR_TEST_B) begin
      v = {q.test_b, 3'h0};
    end else if (addr == vdc_pkg::VDC_ADDR_TEST_C) begin
      v = tcd[15:8];
    end else if (addr == vdc_pkg::VDC_ADDR_TEST_D) begin
      v = tcd[7:0];
    end
    return v;
  endfunction

  // Serial slave state machine and register writes.
  always_comb begin
    logic [7:0] rd_now;
    rd_now = rd_mux(s_q.ptr, s_q, status_byte, div_high, div_active, stat_s[15:0]);
    s_d = s_q;
    s_d.scl_prev = scl_s;
    s_d.sda_prev = sda_s;
    wr_high = 1'b0;
    wr_low = 1'b0;
    wr_byte = rx_byte;
    if (stop_cond) begin
      s_d.st = vdc_pkg::VDC_IDLE;
      s_d.oe = 1'b0;
    end else if (start_cond) begin
      s_d.st = vdc_pkg::VDC_DEV;
      s_d.cnt = 3'h0;
      s_d.acked = 1'b0;
      s_d.oe = 1'b0;
    end else begin
      case (s_q.st)
        vdc_pkg::VDC_IDLE: begin
          s_d.oe = 1'b0;
        end
        vdc_pkg::VDC_DEV: begin
          if (rise) begin
            s_d.shift = rx_byte;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
              s_d.acked = 1'b0;
              s_d.rd_mode = rx_byte[0];
              if (rx_byte[7:1] == DEV_ADDR) begin
                s_d.st = vdc_pkg::VDC_DEV_ACK;
              end else begin
                s_d.st = vdc_pkg::VDC_IDLE;
              end
            end
          end
        end
        vdc_pkg::VDC_DEV_ACK: begin
          if (fall && !s_q.acked) begin
            s_d.oe = 1'b1;
            s_d.acked = 1'b1;
          end else if (fall && s_q.rd_mode) begin
            s_d.st = vdc_pkg::VDC_RD;
            s_d.tx = {rd_now[6:0], 1'b0};
            s_d.oe = ~rd_now[7];
            s_d.cnt = 3'h0;
          end else if (fall) begin
            s_d.st = vdc_pkg::VDC_SUB;
            s_d.oe = 1'b0;
            s_d.cnt = 3'h0;
          end
        end
        vdc_pkg::VDC_SUB: begin
          if (rise) begin
            s_d.shift = rx_byte;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
              s_d.ptr = rx_byte;
              s_d.acked = 1'b0;
              s_d.st = vdc_pkg::VDC_SUB_ACK;
            end
          end
        end
        vdc_pkg::VDC_SUB_ACK, vdc_pkg::VDC_WR_ACK: begin
          if (fall && !s_q.acked) begin
            s_d.oe = 1'b1;
            s_d.acked = 1'b1;
          end else if (fall) begin
            s_d.oe = 1'b0;
            s_d.cnt = 3'h0;
            s_d.st = vdc_pkg::VDC_WR;
          end
        end
        vdc_pkg::VDC_WR: begin
          if (rise) begin
            s_d.shift = rx_byte;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
              s_d.acked = 1'b0;
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.st = vdc_pkg::VDC_WR_ACK;
              if (s_q.ptr == vdc_pkg::VDC_ADDR_DIV_HIGH) begin
                wr_high = 1'b1;
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_DIV_LOW) begin
                wr_low = 1'b1;
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_CLK_GEN) begin
                s_d.clk_gen = rx_byte[7:3];
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_PHASE) begin
                s_d.phase = rx_byte[7:3];
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_OUT_MODE) begin
                s_d.out_mode = rx_byte;
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_TEST_A) begin
                s_d.test_a = rx_byte;
              end else if (s_q.ptr == vdc_pkg::VDC_ADDR_TEST_B) begin
                s_d.test_b = rx_byte[7:3];
              end
            end
          end
        end
        vdc_pkg::VDC_RD: begin
          if (fall) begin
            s_d.oe = ~s_q.tx[7];
            s_d.tx = {s_q.tx[6:0], 1'b0};
          end else if (rise) begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.st = vdc_pkg::VDC_RD_ACK;
            end
          end
        end
        vdc_pkg::VDC_RD_ACK: begin
          if (fall) begin
            s_d.oe = 1'b0;
          end else if (rise && !sda_s) begin
            s_d.st = vdc_pkg::VDC_RD;
            s_d.tx = rd_now;
            s_d.cnt = 3'h0;
          end else if (rise) begin
            s_d.st = vdc_pkg::VDC_IDLE;
          end
        end
        default: begin
          s_d.st = vdc_pkg::VDC_IDLE;
          s_d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q.st <= vdc_pkg::VDC_IDLE;
      s_q.cnt <= 3'h0;
      s_q.acked <= 1'b0;
      s_q.rd_mode <= 1'b0;
      s_q.shift <= 8'h00;
      s_q.tx <= 8'h00;
      s_q.oe <= 1'b0;
      s_q.ptr <= 8'h00;
      s_q.scl_prev <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.clk_gen <= {vdc_pkg::VDC_RST_OSC_RANGE, vdc_pkg::VDC_RST_PUMP};
      s_q.phase <= vdc_pkg::VDC_RST_PHASE;
      s_q.out_mode <= vdc_pkg::VDC_RST_OUT_MODE;
      s_q.test_a <= vdc_pkg::VDC_RST_TEST_A;
      s_q.test_b <= vdc_pkg::VDC_RST_TEST_B;
    end else begin
      s_q <= s_d;
    end
  end

  // Open-drain data pin: only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe_out = s_q.oe;

  // Configuration outputs straight from the register flip-flops.
  assign pixel_clock_divider_out = div_active;
  assign oscillator_range_out = s_q.clk_gen[4:3];
  assign pump_current_out = s_q.clk_gen[2:0];
  assign sampling_phase_out = s_q.phase;
  assign dual_channel_out = s_q.out_mode[vdc_pkg::VDC_OM_DUAL];
  assign parallel_out = s_q.out_mode[vdc_pkg::VDC_OM_PARALLEL];
  assign port_b_first_out = s_q.out_mode[vdc_pkg::VDC_OM_PORT_B];
  assign format_422_out = s_q.out_mode[vdc_pkg::VDC_OM_FMT422];
  assign input_mux_out = s_q.out_mode[vdc_pkg::VDC_OM_MUX];
  assign input_bw_out = s_q.out_mode[vdc_pkg::VDC_OM_BW_HI:vdc_pkg::VDC_OM_BW_LO];
  assign pll_bypass_out = s_q.out_mode[vdc_pkg::VDC_OM_EXT_CLK];
  assign test_a_out = s_q.test_a;
  assign test_b_out = s_q.test_b;

endmodule

// File: testbench/vdc_regs_assertions.sv
`timescale 1ns/1ps
// Checks reset values and that settings move only while a written bit is taken, the phase only while the clock is high.
module vdc_regs_assertions (
  input wire logic ref_clk_in, // Core clock.
  input wire logic resetn_in, // Reset, active low.
  input wire logic scl_in, // Serial clock.
  input wire logic sda_oe_out, // Data pull enable.
  input wire logic [11:0] pixel_clock_divider_out, // Divider.
  input wire logic [1:0] oscillator_range_out, // Range code.
  input wire logic [2:0] pump_current_out, // Pump code.
  input wire logic [4:0] sampling_phase_out, // Phase step.
  input wire logic dual_channel_out, // Dual mode.
  input wire logic parallel_out, // Parallel mode.
  input wire logic port_b_first_out, // Port B first.
  input wire logic format_422_out, // 4:2:2 mode.
  input wire logic input_mux_out, // Mux control.
  input wire logic [1:0] input_bw_out, // Bandwidth code.
  input wire logic pll_bypass_out, // Clock bypass.
  input wire logic [7:0] test_a_out, // First test register.
  input wire logic [4:0] test_b_out // Second test register.
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Mode bits gathered in register order.
  logic [7:0] mode;
  assign mode = {dual_channel_out, parallel_out, port_b_first_out, format_422_out,
                 input_mux_out, input_bw_out, pll_bypass_out};

  // A written bit is being taken: clock high and the device not pulling.
  sequence s_bit_taken;
    scl_in && !sda_oe_out;
  endsequence
  // The divider then stays put for the next eight core clocks.
  sequence s_hold_div;
    $stable(pixel_clock_divider_out) [*8];
  endsequence

  a_reset_divider: assert property (
    $rose(resetn_in) |-> pixel_clock_divider_out == 12'h69D)
    else $error("divider not at power-up value");
  a_reset_settings: assert property (
    $rose(resetn_in) |-> {oscillator_range_out, pump_current_out, sampling_phase_out} == 10'h130
      && mode == 8'hC6 && test_a_out == 8'hFF && test_b_out == 5'h00)
    else $error("settings not at power-up values");
  a_reset_quiet: assert property (
    $rose(resetn_in) |-> !sda_oe_out [*3])
    else $error("data pulled right after reset");
  a_divider_apply: assert property (
    $changed(pixel_clock_divider_out) |-> s_bit_taken ##1 s_hold_div)
    else $error("divider moved outside a written bit");
  a_range_pump: assert property (
    $changed({oscillator_range_out, pump_current_out}) |-> s_bit_taken)
    else $error("range or pump moved outside a write");
  a_phase_write: assert property (
    $changed(sampling_phase_out) |-> scl_in ##1 $stable(sampling_phase_out) [*8])
    else $error("phase moved outside a write");
  a_mode_write: assert property (
    $changed(mode) |-> s_bit_taken)
    else $error("mode moved outside a write");
  a_test_write: assert property (
    $changed({test_a_out, test_b_out}) |-> s_bit_taken ##1 $stable(test_a_out) [*4])
    else $error("test register moved outside a write");
  a_pull_scl_low: assert property (
    $changed(sda_oe_out) |-> !scl_in)
    else $error("data pull changed while clock high");
  a_pull_bounded: assert property (
    $rose(sda_oe_out) |-> ##[1:300] $fell(sda_oe_out))
    else $error("data pull held too long");
endmodule

bind vdc_ctrl_regs vdc_regs_assertions u_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .pixel_clock_divider_out(pixel_clock_divider_out), .oscillator_range_out(oscillator_range_out),
  .pump_current_out(pump_current_out), .sampling_phase_out(sampling_phase_out),
  .dual_channel_out(dual_channel_out), .parallel_out(parallel_out),
  .port_b_first_out(port_b_first_out), .format_422_out(format_422_out),
  .input_mux_out(input_mux_out), .input_bw_out(input_bw_out), .pll_bypass_out(pll_bypass_out),
  .test_a_out(test_a_out), .test_b_out(test_b_out));

// File: testbench/vdc_host_model.sv
`timescale 1ns/1ps
// Serial host: drives the clock and only ever pulls data low.
module vdc_host_model (
  input wire logic ref_clk_in, // Core clock.
  input wire logic sda_in, // Resolved data line.
  output logic scl_out, // Serial clock.
  output logic sda_low_out // High pulls data low.
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // One bit: data set while clock low, line sampled mid high phase.
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = !b;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    s = sda_in;
    gap(4);
    scl_out = 1'b0;
    gap(4);
  endtask

  // Start or repeated start, entered with the clock low or idle.
  task automatic start();
    sda_low_out = 1'b0;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_low_out = 1'b1;
    gap(4);
    scl_out = 1'b0;
    gap(4);
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_low_out = 1'b0;
    gap(4);
  endtask

  // Eight bits most significant first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ab, s);
    ack = !s;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    xfer(d, 1'b1, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  // Pointer set by a write, then a repeated start and one byte ended by a refusal.
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    start();
    xfer({dev, 1'b1}, 1'b1, r, k2);
    xfer(8'hFF, 1'b1, d, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask

  // Two data bytes in one transfer, written or read with an ACK between.
  task automatic two_io(input logic [6:0] dev, input logic rnw, input logic [7:0] a,
                        input logic [15:0] wd, output logic [15:0] dr, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    if (rnw) begin
      start();
      xfer({dev, 1'b1}, 1'b1, r, k2);
      xfer(8'hFF, 1'b0, dr[15:8], k3);
      xfer(8'hFF, 1'b1, dr[7:0], r[0]);
    end else begin
      xfer(wd[15:8], 1'b1, r, k2);
      xfer(wd[7:0], 1'b1, r, k3);
    end
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the register bank, driven through the serial host.
module tb_top;
  localparam logic [6:0] DEV = 7'h4C;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value.
  localparam logic [7:0] DA [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h15, 8'h16, 8'h17};
  localparam logic [7:0] DV [8] = '{REV, 8'h69, 8'hD0, 8'h48, 8'h80, 8'hC6, 8'hFF, 8'h00};
  localparam logic [7:0] RO [5] = '{8'h00, 8'h14, 8'h18, 8'h19, 8'h30};
  logic ref_clk_in, resetn_in, scl, host_low, sda_oe, sda_drv, sda_line, ok;
  logic dual, par, portb, fmt, mux, byp;
  logic [1:0] osc, bw;
  logic [2:0] pump, k;
  logic [4:0] phase, tstb;
  logic [7:0] stat, tst_c, tst_d, tsta, rdat;
  logic [11:0] div;
  logic [15:0] pair;
  int n_fail = 0;
  int samples_checked = 0;

  // Open-drain data line with a pull-up.
  assign sda_line = !((sda_oe && !sda_drv) || host_low);

  vdc_ctrl_regs #(.DEV_ADDR(DEV), .SILICON_REV(REV)) uut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .hsync_detect_in(stat[7]),
    .active_hsync_source_in(stat[6]), .hsync_polarity_in(stat[5]), .vsync_detect_in(stat[4]),
    .active_vsync_source_in(stat[3]), .vsync_out_polarity_in(stat[2]),
    .green_sync_detect_in(stat[1]), .pll_hold_polarity_in(stat[0]), .test_c_in(tst_c),
    .test_d_in(tst_d), .pixel_clock_divider_out(div), .oscillator_range_out(osc),
    .pump_current_out(pump), .sampling_phase_out(phase), .dual_channel_out(dual),
    .parallel_out(par), .port_b_first_out(portb), .format_422_out(fmt), .input_mux_out(mux),
    .input_bw_out(bw), .pll_bypass_out(byp), .test_a_out(tsta), .test_b_out(tstb));

  vdc_host_model host (.ref_clk_in(ref_clk_in), .sda_in(sda_line), .scl_out(scl),
                       .sda_low_out(host_low));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(DEV, a, d, ok);
    chk(16'(ok), 16'h0001);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(DEV, a, rdat, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(rdat), 16'(e));
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_fail++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end

  // Main sequence of register accesses.
  initial begin
    resetn_in = 1'b0;
    stat = 8'h00;
    tst_c = 8'h00;
    tst_d = 8'h00;
    repeat (4) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    chk(16'(div), 16'h069D);
    chk(16'({dual, par, portb, fmt, mux, bw, byp}), 16'h00C6);
    chk(16'({osc, pump, phase}), 16'h0130);
    for (int i = 0; i < 8; i++) begin
      rd(DA[i], DV[i]);
    end
    for (int i = 0; i < 8; i++) begin
      stat = 8'h01 << i;
      rd(8'h14, 8'h01 << i);
    end
    tst_c = 8'hA5;
    tst_d = 8'h5A;
    rd(8'h18, 8'hA5);
    rd(8'h19, 8'h5A);
    wr(8'h01, 8'h6A);
    chk(16'(div), 16'h069D);
    rd(8'h01, 8'h6A);
    wr(8'h02, 8'h30);
    chk(16'(div), 16'h06A3);
    wr(8'h02, 8'h50);
    chk(16'(div), 16'h06A5);
    host.two_io(DEV, 1'b0, 8'h01, 16'h6B70, pair, ok);
    chk(16'({ok, div}), 16'h16B7);
    host.two_io(DEV, 1'b1, 8'h01, 16'h0000, pair, ok);
    chk(16'(ok), 16'h0001);
    chk(pair, 16'h6B70);
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'hF0);
    chk(16'(div), 16'h0FFF);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h20);
    chk(16'(div), 16'h0002);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(8'h03, {k[1:0], k, 3'h7});
      chk(16'({osc, pump}), 16'({k[1:0], k}));
      rd(8'h03, {k[1:0], k, 3'h0});
    end
    wr(8'h04, 8'hFF);
    chk(16'(phase), 16'h001F);
    wr(8'h04, 8'h07);
    chk(16'(phase), 16'h0000);
    wr(8'h15, 8'h21);
    chk(16'({dual, par, portb, fmt, mux, bw, byp}), 16'h0021);
    wr(8'h15, 8'hDE);
    chk(16'({dual, par, portb, fmt, mux, bw, byp}), 16'h00DE);
    wr(8'h16, 8'hFE);
    chk(16'(tsta), 16'h00FE);
    wr(8'h17, 8'h07);
    chk(16'(tstb), 16'h0000);
    rd(8'h17, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(RO[i], 8'hA5);
    end
    rd(8'h00, REV);
    rd(8'h30, 8'h00);
    chk(16'({div, tsta[3:0]}), 16'h002E);
    host.write_reg(7'h4D, 8'h16, 8'h00, ok);
    chk(16'({ok, tsta}), 16'h00FE);
    resetn_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk(16'({div, tsta[3:0]}), 16'h69DF);
    resetn_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    rd(8'h15, 8'hC6);
    test_done();
  end
endmodule
